/* File: include/wdt_cfg.svh */
// watchdog constants: register offsets, field positions, reset values and timing counts
`ifndef WDT_CFG_SVH
`define WDT_CFG_SVH

// register offsets on the plain register port
`define WDT_OFS_CTRL     4'h0
`define WDT_OFS_STAT     4'h1
`define WDT_OFS_ISTAT    4'h2
`define WDT_OFS_IMASK    4'h3
`define WDT_OFS_CNT      4'h4

// watchdog_control fields
`define WDT_EN_BIT       0
`define WDT_PS_LSB       1
`define WDT_PS_MSB       5

// status register fields
`define WDT_ST_ACTIVE    0
`define WDT_ST_TMO_N     1
`define WDT_ST_PWD_N     2
`define WDT_ST_STATE_LSB 3
`define WDT_ST_MODE_LSB  5

// interrupt bit positions
`define WDT_IRQ_WAKE     0
`define WDT_IRQ_OSCF     1
`define WDT_IRQ_HALF     2
`define WDT_IRQ_N        3

// reset values
`define WDT_PS_RST       5'h0B
`define WDT_EN_RST       1'b0
`define WDT_IMASK_RST    3'h0

// period select decode
`define WDT_PS_MIN_SHIFT 5'h05
`define WDT_PS_MAX_CODE  5'h12

// timing: system clock and low-frequency oscillator rates in Hz
`define WDT_CLK_HZ       20000000
`define WDT_LFOSC_HZ     31000
`define WDT_LF_DIV       ((`WDT_CLK_HZ) / (`WDT_LFOSC_HZ))

`endif

/* File: include/wdt_pkg.sv */
// watchdog types and the period decode function
`include "wdt_cfg.svh"

package wdt_pkg;

    // operating mode from the configuration word
    typedef enum logic [1:0] {
        mode_always_off    = 2'h0,
        mode_sw_controlled = 2'h1,
        mode_off_in_sleep  = 2'h2,
        mode_always_on     = 2'h3
    } wdt_mode_t;

    // device power state seen by the watchdog, gray along awake-sleep-hold
    typedef enum logic [1:0] {
        st_awake = 2'h0,
        st_sleep = 2'h1,
        st_hold  = 2'h3
    } wdt_state_t;

    // last count of a period: 2^(code+5)-1, reserved codes fall back to minimum
    function automatic logic [22:0] wdt_last_count(input logic [4:0] code);
        logic [4:0]  sh;
        logic [23:0] one;
        sh  = (code > `WDT_PS_MAX_CODE) ? `WDT_PS_MIN_SHIFT : code + `WDT_PS_MIN_SHIFT;
        one = 24'h1 << sh;
        return 23'(one - 24'h1);
    endfunction : wdt_last_count

endpackage : wdt_pkg

/* File: rtl/wdt_count.sv */
// watchdog oscillator tick divider, prescaler counter and expiry detect
`timescale 1ns/1ps
`include "wdt_cfg.svh"

module wdt_count
    import wdt_pkg::*;
(
    // clock and reset
    input  wire logic        clock,
    input  wire logic        resetn,
    // control
    input  wire logic        clear,
    input  wire logic        enable,
    input  wire logic [4:0]  period_code,
    // results
    output logic             expire,
    output logic             half,
    output logic [22:0]      count
);

    logic [9:0]  div_r;     // oscillator tick divider
    logic        tick;      // one-cycle low-frequency enable
    logic [22:0] cnt_r;     // watchdog count
    logic [22:0] last;      // last count of this period
    logic        expire_r;  // expiry pulse
    logic        half_r;    // half-period pulse

    assign tick   = (div_r == 10'(`WDT_LF_DIV - 1));
    assign last   = wdt_last_count(period_code);
    assign expire = expire_r;
    assign half   = half_r;
    assign count  = cnt_r;

    // free-running divider, never touched by clears so the time base stays steady
    always_ff @(posedge clock) begin
        if (!resetn || tick) begin
            div_r <= 10'h000;
        end else begin
            div_r <= div_r + 10'h001;
        end
    end

    // count oscillator ticks; >= catches a period shortened mid-count
    always_ff @(posedge clock) begin
        if (!resetn || clear) begin
            cnt_r <= 23'h000000;
        end else if (enable && tick) begin
            cnt_r <= (cnt_r >= last) ? 23'h000000 : cnt_r + 23'h000001;
        end
    end

    // registered event pulses
    always_ff @(posedge clock) begin
        if (!resetn) begin
            expire_r <= 1'b0;
            half_r   <= 1'b0;
        end else begin
            expire_r <= !clear && enable && tick && (cnt_r >= last);
            half_r   <= !clear && enable && tick && (cnt_r == (last >> 1));
        end
    end

endmodule : wdt_count

/* File: rtl/wdt_irq.sv */
// sticky interrupt status with write-one-to-clear, mask and level output
`timescale 1ns/1ps
`include "wdt_cfg.svh"

module wdt_irq
    import wdt_pkg::*;
(
    // clock and reset
    input  wire logic                  clock,
    input  wire logic                  resetn,
    // events from the watchdog
    input  wire logic [`WDT_IRQ_N-1:0] events,
    // software access
    input  wire logic                  wr_status,
    input  wire logic                  wr_mask,
    input  wire logic [`WDT_IRQ_N-1:0] wdata,
    // state
    output logic [`WDT_IRQ_N-1:0]      status,
    output logic [`WDT_IRQ_N-1:0]      mask,
    output logic                       irq
);

    logic [`WDT_IRQ_N-1:0] status_r;  // sticky event bits
    logic [`WDT_IRQ_N-1:0] mask_r;    // enable per bit

    assign status = status_r;
    assign mask   = mask_r;
    assign irq    = |(status_r & mask_r);

    // one sticky bit per event; a set in the clearing cycle wins
    for (genvar i = 0; i < `WDT_IRQ_N; i++) begin : g_bit
        always_ff @(posedge clock) begin
            if (!resetn) begin
                status_r[i] <= 1'b0;
            end else if (events[i]) begin
                status_r[i] <= 1'b1;
            end else if (wr_status && wdata[i]) begin
                status_r[i] <= 1'b0;
            end
        end
    end

    // mask register
    always_ff @(posedge clock) begin
        if (!resetn) begin
            mask_r <= `WDT_IMASK_RST;
        end else if (wr_mask) begin
            mask_r <= wdata;
        end
    end

endmodule : wdt_irq

/* File: rtl/wdt_top.sv */
// watchdog timer: modes, clearing, expiry routing, status flags and registers
//
// How it works
// - awake expiry without clear forces reset
// - count only from low-frequency oscillator tick
// - mode 11 always active, sleep included
// - mode 10 active awake, off asleep
// - mode 01 follows software enable bit
// - mode 00 off; enable bit ignored
// - period is 2^(code+5) oscillator cycles
// - reserved period codes use minimum ratio
// - reset loads period 01011, enable 0
// - reset, clear, oscillator fail, disable clear
// - sleep entry clears; may resume from zero
// - sleep exit clears; crystal holds until startup
// - sleep expiry wakes, updates timeout flags
// - oscillator divider change leaves count alone
//
// The register addresses and strobed register access were left to the implementer.
`timescale 1ns/1ps
`include "wdt_cfg.svh"

module wdt_top
    import wdt_pkg::*;
(
    // clock and reset
    input  wire logic        clock,
    input  wire logic        resetn,
    // register port
    input  wire logic [3:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    // configuration word
    input  wire logic [1:0]  wdog_mode_cfg,
    // core sleep and clock control
    input  wire logic        sleep_mode,
    input  wire logic        clear_watchdog_instr,
    input  wire logic        osc_fail,
    input  wire logic        osc_startup_timer,
    input  wire logic        sys_clk_is_crystal,
    // reset and wake requests
    output logic             wdog_reset_pulse,
    output logic             wdog_wake_pulse,
    // core status flags, active low
    output logic             timeout_flag_n,
    output logic             powerdown_flag_n,
    // interrupt
    output logic             irq
);


    // declarations

    wdt_mode_t   mode_r;          // configuration captured at reset
    logic        sw_en_r;         // sw_wdog_enable
    logic [4:0]  period_r;        // period_select

    wdt_state_t  state_r;         // device power state
    wdt_state_t  state_nxt;       // next power state
    logic        sleep_d_r;       // sleep level one cycle back
    logic        sleep_enter;     // rising edge of sleep
    logic        sleep_exit;      // falling edge of sleep
    logic        active;          // watchdog allowed to count
    logic        clear;           // combined clear request

    logic        expire;          // expiry pulse from counter
    logic        half;            // half-period pulse
    logic [22:0] count;           // live count

    logic        to_n_r;          // timeout flag, low after expiry
    logic        pwd_n_r;         // powerdown flag, low after sleep
    logic        reset_p_r;       // reset request pulse
    logic        wake_p_r;        // wake request pulse

    logic [7:0]  rdata_r;         // read data, one cycle after strobe
    logic [`WDT_IRQ_N-1:0] ev;    // interrupt events
    logic [`WDT_IRQ_N-1:0] ist;   // interrupt status
    logic [`WDT_IRQ_N-1:0] imsk;  // interrupt mask

    logic        wr_ctrl;         // write to watchdog_control
    logic        wr_istat;        // write to interrupt status
    logic        wr_imask;        // write to interrupt mask


    // mode decode


    // is the watchdog counting for this mode, enable and power state
    function automatic logic wdt_active(input wdt_mode_t m, input logic en,
                                        input logic asleep);
        logic r;
        r = 1'b0;
        unique case (m)
            mode_always_on:     r = 1'b1;

            mode_off_in_sleep:  r = !asleep;

            mode_sw_controlled: r = en;

            mode_always_off:    r = 1'b0;
        endcase
        return r;
    endfunction : wdt_active

    // only the sleep state is asleep; hold counts as awake
    assign active = wdt_active(mode_r, sw_en_r, state_r == st_sleep);


    // configuration capture


    // static fuse word, so taking it in reset is safe
    // with a synchronous reset
    always_ff @(posedge clock) begin
        if (!resetn) begin
            mode_r <= wdt_mode_t'(wdog_mode_cfg);
        end
    end


    // register decode

    assign wr_ctrl  = reg_wr && (reg_addr == `WDT_OFS_CTRL);
    assign wr_istat = reg_wr && (reg_addr == `WDT_OFS_ISTAT);
    assign wr_imask = reg_wr && (reg_addr == `WDT_OFS_IMASK);

    // watchdog_control fields
    always_ff @(posedge clock) begin
        if (!resetn) begin
            period_r <= `WDT_PS_RST;
            sw_en_r  <= `WDT_EN_RST;
        end else if (wr_ctrl) begin
            // bit stored in every mode; it only matters in mode 01
            period_r <= reg_wdata[`WDT_PS_MSB:`WDT_PS_LSB];
            sw_en_r  <= reg_wdata[`WDT_EN_BIT];
        end
    end


    // power state tracking


    // edge detect on the core sleep level (same clock, no sync needed)
    always_ff @(posedge clock) begin
        if (!resetn) begin
            sleep_d_r <= 1'b0;
        end else begin
            sleep_d_r <= sleep_mode;
        end
    end

    assign sleep_enter = sleep_mode && !sleep_d_r;
    assign sleep_exit  = !sleep_mode && sleep_d_r;

    // next power state
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            st_awake: begin
                if (sleep_mode) begin
                    state_nxt = st_sleep;
                end
            end

            st_sleep: begin
                // crystal clock waits for the startup timer
                if (!sleep_mode) begin
                    state_nxt = (sys_clk_is_crystal && osc_startup_timer) ?
                                st_hold : st_awake;
                end
            end

            st_hold: begin
                if (sleep_mode) begin
                    state_nxt = st_sleep;
                end else if (!osc_startup_timer) begin
                    state_nxt = st_awake;
                end
            end

            // unused code 2'h2 falls back to awake
            default: state_nxt = st_awake;
        endcase
    end

    // power state register
    always_ff @(posedge clock) begin
        if (!resetn) begin
            state_r <= st_awake;
        end else begin
            state_r <= state_nxt;
        end
    end


    // clearing


    // clear instr, osc fail, disabled; reset is in the counter
    // sleep exit clears, hold keeps it clear
    // no divider term: divider changes leave the count
    assign clear = clear_watchdog_instr || osc_fail || !active ||
                   sleep_enter || sleep_exit || (state_r == st_hold);


    // counter


    // count runs from the oscillator tick alone
    // period decode lives in the counter
    wdt_count u_count (
        .clock       (clock),
        .resetn      (resetn),
        .clear       (clear),
        .enable      (active),
        .period_code (period_r),
        .expire      (expire),
        .half        (half),
        .count       (count)
    );


    // expiry routing


    // one pulse per expiry, sent to wake or reset by the power state
    always_ff @(posedge clock) begin
        if (!resetn) begin
            reset_p_r <= 1'b0;
            wake_p_r  <= 1'b0;
        end else begin
            reset_p_r <= expire && (state_r != st_sleep);

            wake_p_r  <= expire && (state_r == st_sleep);
        end
    end

    assign wdog_reset_pulse = reset_p_r;
    assign wdog_wake_pulse  = wake_p_r;


    // timeout and powerdown flags


    // both flags read high after reset; expiry wins over a same-cycle clear
    always_ff @(posedge clock) begin
        if (!resetn) begin
            to_n_r  <= 1'b1;
            pwd_n_r <= 1'b1;
        end else if (expire) begin
            to_n_r <= 1'b0;

        end else if (clear_watchdog_instr) begin
            to_n_r  <= 1'b1;
            pwd_n_r <= 1'b1;

        end else if (sleep_enter) begin
            to_n_r  <= 1'b1;
            pwd_n_r <= 1'b0;
        end
    end

    assign timeout_flag_n   = to_n_r;
    assign powerdown_flag_n = pwd_n_r;


    // interrupts


    // events: wake by timeout, oscillator fail clear, half-period warning
    assign ev[`WDT_IRQ_WAKE] = expire && (state_r == st_sleep);
    assign ev[`WDT_IRQ_OSCF] = osc_fail;
    assign ev[`WDT_IRQ_HALF] = half;

    wdt_irq u_irq (
        .clock     (clock),
        .resetn    (resetn),
        .events    (ev),
        .wr_status (wr_istat),
        .wr_mask   (wr_imask),
        .wdata     (reg_wdata[`WDT_IRQ_N-1:0]),
        .status    (ist),
        .mask      (imsk),
        .irq       (irq)
    );


    // register read


    // data stand one cycle after the strobe, else zero;
    // unmapped offsets read zero; no stall
    always_ff @(posedge clock) begin
        if (!resetn || !reg_rd) begin
            rdata_r <= 8'h00;
        end else begin
            unique case (reg_addr)
                // control, top two bits unimplemented
                `WDT_OFS_CTRL: begin
                    rdata_r <= {2'h0, period_r, sw_en_r};
                end

                // live state of the block
                `WDT_OFS_STAT: begin
                    rdata_r <= {1'b0, mode_r, state_r, pwd_n_r, to_n_r, active};
                end

                // interrupt status
                `WDT_OFS_ISTAT: begin
                    rdata_r <= {5'h00, ist};
                end

                // interrupt mask
                `WDT_OFS_IMASK: begin
                    rdata_r <= {5'h00, imsk};
                end

                // top byte of the count, for coarse progress
                `WDT_OFS_CNT: begin
                    rdata_r <= count[22:15];
                end
                default: begin
                    rdata_r <= 8'h00;
                end
            endcase
        end
    end

    assign reg_rdata = rdata_r;

endmodule : wdt_top

/* File: tb/testbench.sv */
// self-checking bench for the watchdog top
`timescale 1ns/1ps
`include "wdt_cfg.svh"

module testbench
    import wdt_pkg::*;
;
    localparam int TICK = `WDT_LF_DIV;  // clocks per oscillator tick
    logic       clock = 1'b0;
    logic       resetn = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic       reg_wr = 1'b0;
    logic       reg_rd = 1'b0;
    logic [1:0] wdog_mode_cfg = 2'h3;
    logic       clear_watchdog_instr = 1'b0;
    logic       osc_fail = 1'b0;
    logic       go_sleep = 1'b0;
    logic       crystal = 1'b0;
    logic [7:0] reg_rdata, rd;
    logic       sleep_mode, osc_startup_timer, sys_clk_is_crystal;
    logic       wdog_reset_pulse, wdog_wake_pulse, timeout_flag_n, powerdown_flag_n, irq;
    int         errors = 0;
    int         check_count = 0;
    int         resets_seen, wakes_seen, n;
    // active per mode: {en1, en0, asleep en1}
    logic [2:0] act [4] = '{3'b000, 3'b101, 3'b110, 3'b111};

    always #25 clock = ~clock;

    wdt_top dut (
        .clock(clock), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .wdog_mode_cfg(wdog_mode_cfg), .sleep_mode(sleep_mode),
        .clear_watchdog_instr(clear_watchdog_instr), .osc_fail(osc_fail),
        .osc_startup_timer(osc_startup_timer), .sys_clk_is_crystal(sys_clk_is_crystal),
        .wdog_reset_pulse(wdog_reset_pulse), .wdog_wake_pulse(wdog_wake_pulse),
        .timeout_flag_n(timeout_flag_n), .powerdown_flag_n(powerdown_flag_n), .irq(irq)
    );

    wdt_core_model core (
        .clock(clock), .resetn(resetn), .go_sleep(go_sleep), .crystal(crystal),
        .wdog_reset_pulse(wdog_reset_pulse), .wdog_wake_pulse(wdog_wake_pulse),
        .sleep_mode(sleep_mode), .osc_startup_timer(osc_startup_timer),
        .sys_clk_is_crystal(sys_clk_is_crystal), .resets_seen(resets_seen),
        .wakes_seen(wakes_seen)
    );

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : tally_and_finish

    // mode is taken in reset
    task automatic do_reset(input logic [1:0] mode);
        @(posedge clock);
        resetn        <= 1'b0;
        wdog_mode_cfg <= mode;
        crystal       <= 1'b0;
        repeat (16) @(posedge clock);
        resetn <= 1'b1;
    endtask : do_reset

    task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask : reg_write

    // data stand one cycle after strobe
    task automatic reg_read(input logic [3:0] a, output logic [7:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask : reg_read

    // pulse: 0 clear, 1 osc fail, else sleep
    task automatic strobe(input int which);
        @(posedge clock);
        case (which)
            0: clear_watchdog_instr <= 1'b1;
            1: osc_fail <= 1'b1;
            default: go_sleep <= 1'b1;
        endcase
        @(posedge clock);
        clear_watchdog_instr <= 1'b0;
        osc_fail             <= 1'b0;
        go_sleep             <= 1'b0;
    endtask : strobe

    // request within two ticks of nominal
    task automatic expect_expiry(input logic wake, input int ticks, input string what);
        int lim;
        lim = (ticks + 2) * TICK;
        for (n = 0; n < lim; n++) begin
            @(posedge clock);
            #1;
            if ((wake ? wdog_wake_pulse : wdog_reset_pulse) === 1'b1) break;
        end
        check(what, {7'h0, n >= (ticks - 2) * TICK && n < lim}, 8'h01);
        if (n >= lim) tally_and_finish();
    endtask : expect_expiry

    initial begin
        do_reset(2'h3);
        reg_read(`WDT_OFS_CTRL, rd);
        check("ctrl reset", rd, 8'h16);
        reg_read(`WDT_OFS_STAT, rd);
        check("status reset", rd, 8'h67);
        reg_write(`WDT_OFS_CTRL, 8'hFF);
        reg_read(`WDT_OFS_CTRL, rd);
        check("ctrl write", rd, 8'h3F);
        reg_read(4'hF, rd);
        check("unmapped", rd, 8'h00);
        reg_read(`WDT_OFS_IMASK, rd);
        check("mask reset", rd, 8'h00);
        $display("test registers done");
        // every mode against enable and sleep
        for (int m = 0; m < 4; m++) begin
            do_reset(2'(m));
            reg_write(`WDT_OFS_CTRL, 8'h17);
            reg_read(`WDT_OFS_STAT, rd);
            check("active en1", {7'h0, rd[0]}, {7'h0, act[m][2]});
            reg_write(`WDT_OFS_CTRL, 8'h16);
            reg_read(`WDT_OFS_STAT, rd);
            check("active en0", {7'h0, rd[0]}, {7'h0, act[m][1]});
            reg_write(`WDT_OFS_CTRL, 8'h17);
            strobe(2);
            repeat (2) @(posedge clock);
            reg_read(`WDT_OFS_STAT, rd);
            check("active asleep", {7'h0, rd[0]}, {7'h0, act[m][0]});
            check("sleep state", {6'h0, rd[4:3]}, 8'h01);
            check("pd flag", {7'h0, powerdown_flag_n}, 8'h00);
        end
        $display("test modes done");
        // awake expiry at the shortest period
        do_reset(2'h3);
        reg_write(`WDT_OFS_CTRL, 8'h00);
        expect_expiry(1'b0, 32, "awake expiry");
        repeat (2) @(posedge clock);
        check("resets", 8'(resets_seen), 8'h01);
        check("to flag", {7'h0, timeout_flag_n}, 8'h00);
        $display("test awake expiry done");
        // reserved code; clear and oscillator fail restart the count
        do_reset(2'h3);
        reg_write(`WDT_OFS_CTRL, 8'h3E);
        repeat (12 * TICK) @(posedge clock);
        strobe(0);
        repeat (24 * TICK) @(posedge clock);
        check("clear held off", 8'(resets_seen), 8'h00);
        strobe(1);
        expect_expiry(1'b0, 32, "reserved expiry");
        reg_read(`WDT_OFS_ISTAT, rd);
        check("osc fail event", {7'h0, rd[1]}, 8'h01);
        check("irq masked", {7'h0, irq}, 8'h00);
        $display("test clearing done");
        // sleep expiry wakes; crystal wake holds for start-up
        do_reset(2'h3);
        crystal <= 1'b1;
        reg_write(`WDT_OFS_CTRL, 8'h00);
        reg_write(`WDT_OFS_IMASK, 8'h01);
        repeat (4 * TICK) @(posedge clock);
        strobe(2);
        expect_expiry(1'b1, 32, "sleep expiry");
        repeat (2) @(posedge clock);
        check("no reset asleep", 8'(resets_seen), 8'h00);
        check("flags", {6'h0, timeout_flag_n, powerdown_flag_n}, 8'h00);
        check("irq raised", {7'h0, irq}, 8'h01);
        reg_read(`WDT_OFS_STAT, rd);
        check("hold state", {6'h0, rd[4:3]}, 8'h03);
        reg_write(`WDT_OFS_ISTAT, 8'h01);
        reg_read(`WDT_OFS_ISTAT, rd);
        check("wake cleared", {7'h0, rd[0]}, 8'h00);
        check("irq cleared", {7'h0, irq}, 8'h00);
        for (n = 0; n < 2000 && osc_startup_timer; n++) @(posedge clock);
        check("startup ends", {7'h0, osc_startup_timer}, 8'h00);
        reg_read(`WDT_OFS_STAT, rd);
        check("awake state", {6'h0, rd[4:3]}, 8'h00);
        $display("test sleep wake done");
        tally_and_finish();
    end
endmodule : testbench

/* File: tb/wdt_core_model.sv */
// model of the core reset, sleep and clock control facing the watchdog
`timescale 1ns/1ps

module wdt_core_model
    import wdt_pkg::*;
#(
    parameter int STARTUP_CYCLES = 1024  // start-up hold after a crystal wake
)
(
    // clock and reset
    input  wire logic clock,
    input  wire logic resetn,
    // bench commands
    input  wire logic go_sleep,
    input  wire logic crystal,
    // watchdog requests
    input  wire logic wdog_reset_pulse,
    input  wire logic wdog_wake_pulse,
    // core state and request counts
    output logic      sleep_mode,
    output logic      osc_startup_timer,
    output logic      sys_clk_is_crystal,
    output int        resets_seen,
    output int        wakes_seen
);
    int ost_left_r;  // start-up cycles still to run

    // sleep until a wake; a crystal then runs start-up
    always_ff @(posedge clock) begin
        if (!resetn) begin
            sleep_mode  <= 1'b0;
            ost_left_r  <= 0;
            resets_seen <= 0;
            wakes_seen  <= 0;
        end else begin
            if (go_sleep) begin
                sleep_mode <= 1'b1;
            end else if (wdog_wake_pulse) begin
                sleep_mode <= 1'b0;
                ost_left_r <= crystal ? STARTUP_CYCLES : 0;
            end else if (ost_left_r != 0) begin
                ost_left_r <= ost_left_r - 1;
            end
            resets_seen <= resets_seen + int'(wdog_reset_pulse);
            wakes_seen  <= wakes_seen + int'(wdog_wake_pulse);
        end
    end

    assign osc_startup_timer  = (ost_left_r != 0);
    assign sys_clk_is_crystal = crystal;
endmodule : wdt_core_model

/* File: tb/wdt_top_properties.sv */
// concurrent checks on the watchdog top ports, bound into wdt_top
`timescale 1ns/1ps
`include "wdt_cfg.svh"

module wdt_top_properties
    import wdt_pkg::*;
(
    // clock and reset
    input  wire logic       clock,
    input  wire logic       resetn,
    // register port
    input  wire logic [3:0] reg_addr,
    input  wire logic       reg_rd,
    input  wire logic [7:0] reg_rdata,
    // configuration and core side
    input  wire logic [1:0] wdog_mode_cfg,
    input  wire logic       sleep_mode,
    input  wire logic       clear_watchdog_instr,
    // requests and flags
    input  wire logic       wdog_reset_pulse,
    input  wire logic       wdog_wake_pulse,
    input  wire logic       timeout_flag_n,
    input  wire logic       powerdown_flag_n
);
    logic [1:0] mode_r;        // mode word captured while reset is held
    logic [3:0] sleep_hist_r;  // sleep level over the last four edges

    // mode word is taken in reset
    always_ff @(posedge clock) begin
        if (!resetn) begin
            mode_r <= wdog_mode_cfg;
        end
    end

    // sleep history covers the pipeline delay
    always_ff @(posedge clock) begin
        sleep_hist_r <= {sleep_hist_r[2:0], sleep_mode};
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);

    property p_excl; !(wdog_reset_pulse && wdog_wake_pulse); endproperty
    a_excl: assert property (p_excl) else $error("reset and wake together");
    property p_reset_one; wdog_reset_pulse |=> !wdog_reset_pulse; endproperty
    a_reset_one: assert property (p_reset_one) else $error("long reset pulse");
    property p_wake_one; wdog_wake_pulse |=> !wdog_wake_pulse; endproperty
    a_wake_one: assert property (p_wake_one) else $error("long wake pulse");
    property p_wake_asleep; wdog_wake_pulse |-> sleep_hist_r != 4'h0; endproperty
    a_wake_asleep: assert property (p_wake_asleep) else $error("wake while awake");
    property p_reset_awake; wdog_reset_pulse |-> sleep_hist_r != 4'hF; endproperty
    a_reset_awake: assert property (p_reset_awake) else $error("reset in sleep");
    property p_to_on_wake; wdog_wake_pulse |-> ##[0:2] !timeout_flag_n; endproperty
    a_to_on_wake: assert property (p_to_on_wake) else $error("timeout flag high");
    property p_pd; $rose(sleep_mode) |-> ##[1:2] !powerdown_flag_n; endproperty
    a_pd: assert property (p_pd) else $error("powerdown flag high");
    property p_clr; clear_watchdog_instr |-> ##3 !wdog_reset_pulse [*8]; endproperty
    a_clr: assert property (p_clr) else $error("reset after clear");
    property p_off; mode_r == 2'h0 |-> !wdog_reset_pulse && !wdog_wake_pulse; endproperty
    a_off: assert property (p_off) else $error("request in off mode");
    property p_ns; mode_r == 2'h2 && sleep_hist_r == 4'hF |-> !wdog_wake_pulse; endproperty
    a_ns: assert property (p_ns) else $error("wake in mode 10");
    property p_off_rd;
        $past(reg_rd) && $past(reg_addr) == `WDT_OFS_STAT && mode_r == 2'h0
            |-> reg_rdata[0] == 1'b0;
    endproperty
    a_off_rd: assert property (p_off_rd) else $error("active in off mode");
endmodule : wdt_top_properties

bind wdt_top wdt_top_properties u_props (
    .clock(clock), .resetn(resetn), .reg_addr(reg_addr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .wdog_mode_cfg(wdog_mode_cfg), .sleep_mode(sleep_mode),
    .clear_watchdog_instr(clear_watchdog_instr), .wdog_reset_pulse(wdog_reset_pulse),
    .wdog_wake_pulse(wdog_wake_pulse), .timeout_flag_n(timeout_flag_n),
    .powerdown_flag_n(powerdown_flag_n)
);
